//--- logic/arith_mul_div_overflow.sv
// Purpose: add, subtract, multiply and divide on one's complement words
// Assumes: commands come from logic on the same clock, one at a time
// Notes: multiply and divide iterate once per operand bit
// Overview of operation
// - add multiplicand when multiplier bit is one
// - shift multiplicand left after each multiplier bit
// - product register 2W-1 bits never overflows
// - divide restoring: subtract, add back, shift right
// - quotient bit one keeps subtraction, else zero
// - add by subtracting complemented addend, end-around borrow
// - add overflow: like signs, sum sign differs
// - subtract overflow: unlike signs, result sign equals subtrahend
// - divide overflow checked before the steps begin
`timescale 1ns/10ps
module arith_mul_div_overflow
  import arith_pkg::*;
#(
  parameter int W = WORD_W_DEF
) (
  input wire logic clk,
  input wire logic rst,
  input wire cmd_type cmd,
  input wire logic [W-1:0] a,
  input wire logic [W-1:0] b,
  output logic [2*W-2:0] result_q,
  output logic [W-1:0] remainder_q,
  output status_type status_q
);

  localparam int CNT_W = $clog2(W + 1);
  localparam int PW = 2 * W - 1;
  localparam int MUL_LAT = W + 1;

  typedef enum logic [1:0] {ST_IDLE, ST_MUL, ST_DIV} state_type;

  // magnitude of a one's complement word
  function automatic logic [W-2:0] mag(input logic [W-1:0] x);
    mag = x[W-1] ? ~x[W-2:0] : x[W-2:0];
  endfunction : mag

  // widen a word to the product width by copying its sign
  function automatic logic [PW-1:0] sext(input logic [W-1:0] x);
    sext = {{(W-1){x[W-1]}}, x};
  endfunction : sext

  state_type state_q, state_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic [PW-1:0] acc_q, acc_d, shf_q, shf_d, result_d;
  logic [W-1:0] mq_q, mq_d, rem_d;
  logic neg_q, neg_d, rneg_q, rneg_d;
  status_type stat_d;
  logic [W-2:0] hold_a_q, hold_a_d, hold_b_q, hold_b_d;
  logic hold_neg_q, hold_neg_d;
  op_type hold_op_q, hold_op_d;
  logic accept;
  logic [W-1:0] sub_b, sub_diff;
  logic add_ovf, sub_ovf;
  logic [PW:0] trial;

  // commands are taken only while idle; a busy unit ignores start
  assign accept = cmd.start && (state_q == ST_IDLE);
  // adding is done by subtracting the complemented addend
  assign sub_b = (cmd.op == OP_ADD) ? ~b : b;
  ones_sub #(.W(W)) u_sub (
    .minuend(a),
    .subtrahend(sub_b),
    .diff(sub_diff),
    .wrap()
  );
  // overflow tests look only at the signs
  assign add_ovf = (a[W-1] == b[W-1]) && (sub_diff[W-1] != a[W-1]);
  assign sub_ovf = (a[W-1] != b[W-1]) && (sub_diff[W-1] == b[W-1]);

  // trial subtraction of the aligned divisor from the partial dividend
  assign trial = {1'b0, acc_q} - {1'b0, shf_q};

  // next state of the whole datapath
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    acc_d = acc_q;
    shf_d = shf_q;
    mq_d = mq_q;
    neg_d = neg_q;
    rneg_d = rneg_q;
    result_d = result_q;
    rem_d = remainder_q;
    stat_d = status_q;
    stat_d.done = 1'b0;
    hold_a_d = hold_a_q;
    hold_b_d = hold_b_q;
    hold_neg_d = hold_neg_q;
    hold_op_d = hold_op_q;
    case (state_q)
      ST_IDLE: begin
        if (accept) begin
          stat_d.ovf = 1'b0;
          stat_d.div_fault = 1'b0;
          hold_a_d = mag(a);
          hold_b_d = mag(b);
          hold_neg_d = a[W-1] ^ b[W-1];
          hold_op_d = cmd.op;
          case (cmd.op)
            OP_ADD, OP_SUB: begin
              result_d = sext(sub_diff);
              stat_d.ovf = (cmd.op == OP_ADD) ? add_ovf : sub_ovf;
              stat_d.done = 1'b1;
            end
            OP_MUL: begin
              acc_d = '0;
              shf_d = {{W{1'b0}}, mag(a)};
              mq_d = {1'b0, mag(b)};
              neg_d = a[W-1] ^ b[W-1];
              cnt_d = CNT_W'(W);
              state_d = ST_MUL;
            end
            default: begin
              // a zero divisor gives a quotient beyond any register
              if (mag(b) == '0) begin
                result_d = '0;
                stat_d.ovf = 1'b1;
                stat_d.div_fault = 1'b1;
                stat_d.done = 1'b1;
              end else begin
                acc_d = {{W{1'b0}}, mag(a)};
                shf_d = {1'b0, mag(b), {(W-1){1'b0}}};
                mq_d = '0;
                neg_d = a[W-1] ^ b[W-1];
                rneg_d = a[W-1];
                cnt_d = CNT_W'(W);
                state_d = ST_DIV;
              end
            end
          endcase
        end
      end
      ST_MUL: begin
        // magnitudes only, so the sign is applied once at the end
        acc_d = mq_q[0] ? acc_q + shf_q : acc_q;
        shf_d = shf_q << 1;
        mq_d = mq_q >> 1;
        cnt_d = cnt_q - CNT_W'(1);
        if (cnt_q == CNT_W'(1)) begin
          result_d = neg_q ? ~acc_d : acc_d;
          stat_d.done = 1'b1;
          state_d = ST_IDLE;
        end
      end
      ST_DIV: begin
        // a negative trial is undone by adding the divisor back once
        if (trial[PW]) begin
          acc_d = trial[PW-1:0] + shf_q;
        end else begin
          acc_d = trial[PW-1:0];
        end
        mq_d = {mq_q[W-2:0], ~trial[PW]};
        shf_d = shf_q >> 1;
        cnt_d = cnt_q - CNT_W'(1);
        if (cnt_q == CNT_W'(1)) begin
          result_d = sext(neg_q ? ~mq_d : mq_d);
          rem_d = rneg_q ? ~acc_d[W-1:0] : acc_d[W-1:0];
          stat_d.done = 1'b1;
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
    stat_d.busy = (state_d != ST_IDLE);
  end

  // registers only; outputs come straight from here
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= ST_IDLE;
      cnt_q <= '0;
      acc_q <= '0;
      shf_q <= '0;
      mq_q <= '0;
      neg_q <= FLAG_RST;
      rneg_q <= FLAG_RST;
      result_q <= '0;
      remainder_q <= '0;
      status_q <= '{FLAG_RST, FLAG_RST, FLAG_RST, FLAG_RST};
      hold_a_q <= '0;
      hold_b_q <= '0;
      hold_neg_q <= FLAG_RST;
      hold_op_q <= OP_ADD;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      acc_q <= acc_d;
      shf_q <= shf_d;
      mq_q <= mq_d;
      neg_q <= neg_d;
      rneg_q <= rneg_d;
      result_q <= result_d;
      remainder_q <= rem_d;
      status_q <= stat_d;
      hold_a_q <= hold_a_d;
      hold_b_q <= hold_b_d;
      hold_neg_q <= hold_neg_d;
      hold_op_q <= hold_op_d;
    end
  end

  // reference values for the checks below
  logic [W:0] ref_raw;
  logic [W-1:0] ref_sum;
  logic [PW-2:0] ref_prod;
  logic [PW-1:0] ref_mul;
  logic mul_done, div_done;
  // additive one's complement sum with end-around carry
  assign ref_raw = {1'b0, a} + {1'b0, b};
  assign ref_sum = ref_raw[W-1:0] + {{(W-1){1'b0}}, ref_raw[W]};
  assign ref_prod = {{(W-1){1'b0}}, hold_a_q} * {{(W-1){1'b0}}, hold_b_q};
  assign ref_mul = hold_neg_q ? ~{1'b0, ref_prod} : {1'b0, ref_prod};
  assign mul_done = status_q.done && (hold_op_q == OP_MUL);
  assign div_done = status_q.done && (hold_op_q == OP_DIV)
    && !status_q.div_fault;

  property p_add_ovf;
    @(posedge clk) disable iff (rst)
    accept && (cmd.op == OP_ADD) |=> status_q.done
      && (status_q.ovf == (($past(a[W-1]) == $past(b[W-1]))
      && (result_q[W-1] != $past(a[W-1]))));
  endproperty
  a_add_ovf: assert property (p_add_ovf)
    else $error("add overflow flag wrong");
  property p_sub_ovf;
    @(posedge clk) disable iff (rst)
    accept && (cmd.op == OP_SUB) |=> status_q.done
      && (status_q.ovf == (($past(a[W-1]) != $past(b[W-1]))
      && (result_q[W-1] == $past(b[W-1]))));
  endproperty
  a_sub_ovf: assert property (p_sub_ovf)
    else $error("subtract overflow flag wrong");

  property p_add_value;
    @(posedge clk) disable iff (rst)
    accept && (cmd.op == OP_ADD) |=> (result_q[W-1:0] == $past(ref_sum))
      || ((result_q[W-1:0] == '0) && ($past(ref_sum) == '1));
  endproperty
  a_add_value: assert property (p_add_value)
    else $error("add result wrong");

  property p_mul_lat;
    @(posedge clk) disable iff (rst)
    accept && (cmd.op == OP_MUL) |-> ##MUL_LAT status_q.done;
  endproperty
  a_mul_lat: assert property (p_mul_lat)
    else $error("multiply done late or early");
  property p_mul_value;
    @(posedge clk) disable iff (rst)
    mul_done |-> (result_q == ref_mul);
  endproperty
  a_mul_value: assert property (p_mul_value)
    else $error("product wrong");
  property p_mul_sign;
    @(posedge clk) disable iff (rst)
    mul_done |-> (result_q[PW-1] == hold_neg_q) && !status_q.ovf;
  endproperty
  a_mul_sign: assert property (p_mul_sign)
    else $error("product sign lost");

  property p_div_quot;
    @(posedge clk) disable iff (rst)
    div_done |-> (mag(result_q[W-1:0]) == hold_a_q / hold_b_q);
  endproperty
  a_div_quot: assert property (p_div_quot)
    else $error("quotient wrong");
  property p_div_rem;
    @(posedge clk) disable iff (rst)
    div_done |-> (mag(remainder_q) == hold_a_q % hold_b_q);
  endproperty
  a_div_rem: assert property (p_div_rem)
    else $error("remainder wrong");

  property p_div_fault;
    @(posedge clk) disable iff (rst)
    accept && (cmd.op == OP_DIV) && (mag(b) == '0) |=> status_q.done
      && status_q.div_fault && !status_q.busy;
  endproperty
  a_div_fault: assert property (p_div_fault)
    else $error("divide fault not raised at once");
  property p_div_lat;
    @(posedge clk) disable iff (rst)
    accept && (cmd.op == OP_DIV) && (mag(b) != '0) |-> ##MUL_LAT
      status_q.done && !status_q.div_fault;
  endproperty
  a_div_lat: assert property (p_div_lat)
    else $error("divide done late or early");

endmodule : arith_mul_div_overflow

//--- logic/arith_pkg.sv
// Purpose: shared types and constants for the arithmetic datapath
// Assumes: one's complement words, operand width set per instance
// Notes: status travels as one packed struct
package arith_pkg;

  // operand width used when an instance does not override it
  localparam int WORD_W_DEF = 16;

  // reset value of every status flag
  localparam logic FLAG_RST = 1'b0;

  // arithmetic commands from the control section
  typedef enum logic [1:0] {OP_ADD, OP_SUB, OP_MUL, OP_DIV} op_type;

  // one command: a start strobe with its operation
  typedef struct packed {
    logic start;
    op_type op;
  } cmd_type;

  // answer flags back to the control section
  typedef struct packed {
    logic busy;
    logic done;
    logic ovf;
    logic div_fault;
  } status_type;

endpackage : arith_pkg

//--- logic/ones_sub.sv
// Purpose: one's complement subtractor with end-around borrow
// Assumes: both inputs in one's complement form
// Notes: purely combinational, no state
`timescale 1ns/10ps
module ones_sub #(
  parameter int W = 16
) (
  input wire logic [W-1:0] minuend,
  input wire logic [W-1:0] subtrahend,
  output logic [W-1:0] diff,
  output logic wrap
);

  logic [W:0] raw;

  // a borrow out means the result passed through zero, so take one more
  assign raw = {1'b0, minuend} - {1'b0, subtrahend};
  assign wrap = raw[W];
  assign diff = raw[W-1:0] - {{(W-1){1'b0}}, raw[W]};

endmodule : ones_sub

//--- test/ctl_model.sv
// Purpose: control-section stand-in that issues arithmetic commands
// Assumes: called by the bench just after a falling clock edge
// Notes: operands are scrambled once the strobe drops
`timescale 1ns/10ps
module ctl_model
  import arith_pkg::*;
#(
  parameter int W = 8
) (
  output cmd_type cmd,
  output logic [W-1:0] a,
  output logic [W-1:0] b
);
  // idle at time zero
  initial begin
    cmd = '0;
    a = '0;
    b = '0;
  end

  // raise the strobe with its operation and operands
  task put(input op_type op, input logic [W-1:0] x, input logic [W-1:0] y);
    cmd.start = 1'b1;
    cmd.op = op;
    a = x;
    b = y;
  endtask : put

  // operands mean nothing without start, so flip them to expose
  // a unit that samples them late
  task stop();
    cmd.start = 1'b0;
    cmd.op = op_type'(~cmd.op);
    a = ~a;
    b = ~b;
  endtask : stop
endmodule : ctl_model

//--- test/testbench.sv
// Purpose: self-checking bench for the arithmetic datapath
// Assumes: 8-bit one's complement words, commands via ctl_model
// Notes: expected sums and differences come from osub, products and quotients from magnitude arithmetic below
`timescale 1ns/10ps
module testbench import arith_pkg::*;;
  localparam int W = 8;
  localparam int R = 2*W-1;
  logic clk = 1'b0;
  logic rst = 1'b1;
  cmd_type cmd;
  logic [W-1:0] a;
  logic [W-1:0] b;
  logic [R-1:0] result_q;
  logic [W-1:0] remainder_q;
  status_type status_q;
  int errors = 0;
  int total_checks = 0;
  int lat;
  logic busy1;

  // 100 MHz clock
  always #5 clk = ~clk;

  ctl_model #(.W(W)) ctl (.cmd(cmd), .a(a), .b(b));

  arith_mul_div_overflow #(.W(W)) uut (
    .clk(clk),
    .rst(rst),
    .cmd(cmd),
    .a(a),
    .b(b),
    .result_q(result_q),
    .remainder_q(remainder_q),
    .status_q(status_q)
  );

  // compare and count
  task check(input logic [R-1:0] got, input logic [R-1:0] exp,
             input string what);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: %s got %h want %h", $time, what, got,
               exp);
    end
  endtask : check

  // one's complement difference with end-around borrow
  function automatic logic [W-1:0] osub(input logic [W-1:0] x,
                                        input logic [W-1:0] y);
    logic [W:0] t;
    t = {1'b0, x} - {1'b0, y};
    return t[W] ? t[W-1:0] - W'(1) : t[W-1:0];
  endfunction : osub

  function automatic logic [W-1:0] mag(input logic [W-1:0] x);
    return x[W-1] ? ~x : x;
  endfunction : mag

  // issue one command, count falling edges until done; a refused
  // add can be slipped in while the unit is busy
  task automatic run(input op_type op, input logic [W-1:0] x,
                     input logic [W-1:0] y, input bit inj);
    lat = 0;
    ctl.put(op, x, y);
    do begin
      @(negedge clk);
      lat++;
      if (lat == 1) busy1 = status_q.busy;
      if (lat == 1) ctl.stop();
      if (inj && lat == 2) ctl.put(OP_ADD, ~x, ~y);
      if (inj && lat == 3) ctl.stop();
    end while (status_q.done !== 1'b1 && lat < 40);
    @(negedge clk);
  endtask : run

  // add and subtract every cycle, back to back
  task automatic t_addsub();
    logic [W-1:0] xs[8] = '{8'h29, 8'h70, 8'h05, 8'h8f,
                            8'hcf, 8'h70, 8'h8f, 8'h10};
    logic [W-1:0] ys[8] = '{8'h0c, 8'h20, 8'hfa, 8'h9f,
                            8'hca, 8'hdf, 8'h20, 8'h30};
    logic [W-1:0] r;
    logic v;
    ctl.put(OP_ADD, xs[0], ys[0]);
    for (int i = 0; i < 8; i++) begin
      @(negedge clk);
      if (i < 7) ctl.put(i < 3 ? OP_ADD : OP_SUB, xs[i+1], ys[i+1]);
      else ctl.stop();
      r = osub(xs[i], i < 4 ? ~ys[i] : ys[i]);
      if (i < 4) v = xs[i][W-1] == ys[i][W-1] && r[W-1] != xs[i][W-1];
      else v = xs[i][W-1] != ys[i][W-1] && r[W-1] == ys[i][W-1];
      check(R'(status_q.done), R'(1'b1), "add/sub done");
      check(result_q, {{(W-1){r[W-1]}}, r}, "add/sub result");
      check(R'(status_q.ovf), R'(v), "add/sub overflow");
    end
    @(negedge clk);
  endtask : t_addsub

  // shift-and-add products, widest magnitudes included
  task automatic t_mul();
    logic [W-1:0] xs[5] = '{8'h3a, 8'hc5, 8'h7f, 8'h00, 8'h80};
    logic [W-1:0] ys[5] = '{8'h2d, 8'h2d, 8'h7f, 8'h55, 8'h80};
    logic [R-1:0] p;
    for (int i = 0; i < 5; i++) begin
      run(OP_MUL, xs[i], ys[i], i == 0);
      p = R'(mag(xs[i])) * R'(mag(ys[i]));
      if (xs[i][W-1] ^ ys[i][W-1]) p = ~p;
      check(R'(lat), R'(W+1), "mul latency");
      check(R'(busy1), R'(1'b1), "mul busy");
      check(result_q, p, "product");
      check(R'(status_q.ovf), R'(1'b0), "mul overflow");
      check(R'(status_q.done), '0, "done one cycle");
      check(R'(status_q.busy), '0, "idle after done");
    end
  endtask : t_mul

  // restoring division, with a zero-divisor fault first and another between good ones
  task automatic t_div();
    logic [W-1:0] xs[7] = '{8'h40, 8'h75, 8'h40, 8'h8a, 8'h75, 8'h03, 8'h7f};
    logic [W-1:0] ys[7] = '{8'h00, 8'h05, 8'hff, 8'h05, 8'hfa, 8'h64, 8'h01};
    logic [W-1:0] q;
    logic [W-1:0] m;
    for (int i = 0; i < 7; i++) begin
      run(OP_DIV, xs[i], ys[i], 1'b0);
      if (mag(ys[i]) == '0) begin
        check(R'(lat), R'(1), "fault latency");
        check(R'(status_q.div_fault), R'(1'b1), "divide fault");
        check(R'(status_q.ovf), R'(1'b1), "divide overflow");
        check(result_q, '0, "fault result");
      end else begin
        q = mag(xs[i]) / mag(ys[i]);
        m = mag(xs[i]) % mag(ys[i]);
        if (xs[i][W-1] ^ ys[i][W-1]) q = ~q;
        if (xs[i][W-1]) m = ~m;
        check(R'(lat), R'(W+1), "div latency");
        check(result_q, {{(W-1){q[W-1]}}, q}, "quotient");
        check(R'(remainder_q), R'(m), "remainder");
        check(R'(status_q.div_fault), R'(1'b0), "fault cleared");
      end
    end
  endtask : t_div

  // verdict and end of run
  task end_sim();
    if (errors == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_sim

  // main sequence: reset for three cycles, then the scenarios
  initial begin
    repeat (3) @(posedge clk);
    @(negedge clk);
    // outputs are settled here, away from the launching edge
    check(result_q, '0, "reset result");
    check(R'(remainder_q), '0, "reset remainder");
    check(R'(status_q), '0, "reset status");
    rst = 1'b0;
    @(negedge clk);
    t_addsub();
    t_mul();
    t_div();
    end_sim();
  end

  // watchdog, well beyond the roughly 120 cycles the run needs
  initial begin
    #50000;
    errors++;
    end_sim();
  end
endmodule : testbench
